// ### hibr_defs.svh
// constants of the hid report bridge: report layout, timing, register map
//
// Overview of operation
// - malformed out command is not run and returns status bit d0 set
// - a nak from the target aborts the transfer and sets status bit d1
// - lost bus arbitration aborts the transfer and sets status bit d2
// - bus not free within 256 ms or byte over 10 ms sets bit d3
// - status bits d7..d4 echo the sequence number of the out command
// - report byte 1 holds the count of bytes written, 0 to 32
// - report byte 2 holds the count of bytes read; byte 3 is reserved
// - in report is 36 bytes, 32-byte data field from byte 4
// - feature report 0x3c, five bytes, writes a 16-bit register, low first
// - feature report 0x4b, three bytes, latches the read address, low first
// - feature report 0x5a returns the register at the latched address
// - every out command is answered by exactly one in report
// - flag d0 adds start, d1 adds stop, d2 acks the final read
// - direction bit is inserted by the device, address bit 0 ignored
// - every register is 16 bits wide; all but level, which reads the pins, reset to zero
`ifndef HIBR_DEFS_SVH
`define HIBR_DEFS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define HIBR_CLK_KHZ 100000
`define HIBR_FREE_TO_MS 256
`define HIBR_BYTE_TO_MS 10
`define HIBR_FREE_TO_CYC (`HIBR_FREE_TO_MS * `HIBR_CLK_KHZ)
`define HIBR_BYTE_TO_CYC (`HIBR_BYTE_TO_MS * `HIBR_CLK_KHZ)
`define HIBR_TMR_W 25

// ----------------------------------------
// out command and in report layout
// ----------------------------------------
`define HIBR_OUT_ID 8'h00
`define HIBR_OUT_LAST 6'd36
`define HIBR_OB_FLAGS 6'd1
`define HIBR_OB_WCNT 6'd2
`define HIBR_OB_RCNT 6'd3
`define HIBR_OB_ADDR 6'd4
`define HIBR_OB_DATA 6'd5
`define HIBR_IB_STAT 6'd0
`define HIBR_IB_WCNT 6'd1
`define HIBR_IB_RCNT 6'd2
`define HIBR_IB_RSVD 6'd3
`define HIBR_IB_DATA 6'd4
`define HIBR_IN_LAST 6'd35
`define HIBR_DATA_MAX 8'h20
`define HIBR_CF_START 0
`define HIBR_CF_STOP 1
`define HIBR_CF_ACKL 2
`define HIBR_SF_ERR 0
`define HIBR_SF_NAK 1
`define HIBR_SF_ARB 2
`define HIBR_SF_TO 3

// ----------------------------------------
// feature reports
// ----------------------------------------
`define HIBR_FID_WR 8'h3c
`define HIBR_FID_PTR 8'h4b
`define HIBR_FID_RD 8'h5a
`define HIBR_FLEN_WR 3'h5
`define HIBR_FLEN_PTR 3'h3
`define HIBR_FLEN_RD 3'h1
`define HIBR_FIDX_MAX 3'h5

// ----------------------------------------
// register map
// ----------------------------------------
`define HIBR_A_SCL_LO 16'h0341
`define HIBR_A_SCL_HI 16'h0342
`define HIBR_A_FUNC 16'h03c0
`define HIBR_A_DIR 16'h03c1
`define HIBR_A_SET 16'h03c2
`define HIBR_A_CLR 16'h03c3
`define HIBR_A_LEVEL 16'h03c4
`define HIBR_A_HIZ 16'h03c5
`define HIBR_A_OD 16'h03c6
`define HIBR_A_PU 16'h03c7
`define HIBR_A_PD 16'h03c8
`define HIBR_A_IRQM 16'h03c9
`define HIBR_I_SCL_LO 4'h0
`define HIBR_I_SCL_HI 4'h1
`define HIBR_I_FUNC 4'h2
`define HIBR_I_DIR 4'h3
`define HIBR_I_SET 4'h4
`define HIBR_I_CLR 4'h5
`define HIBR_I_LEVEL 4'h6
`define HIBR_I_HIZ 4'h7
`define HIBR_I_OD 4'h8
`define HIBR_I_PU 4'h9
`define HIBR_I_PD 4'ha
`define HIBR_I_IRQM 4'hb
`define HIBR_I_NONE 4'hf
`define HIBR_NREG 12
`define HIBR_REG_RST 16'h0000

`endif

// ### hibr_pkg.sv
// types of the hid report bridge
package hibr_pkg;

	typedef enum logic [3:0] {
		hibr_st_rx = 4'h0,
		hibr_st_waitfree = 4'h1,
		hibr_st_start = 4'h2,
		hibr_st_addr = 4'h3,
		hibr_st_wdata = 4'h4,
		hibr_st_restart = 4'h5,
		hibr_st_raddr = 4'h6,
		hibr_st_rdata = 4'h7,
		hibr_st_stop = 4'h8,
		hibr_st_reply = 4'h9
	} hibr_state_e;

	typedef enum logic [1:0] {
		hibr_cmd_start = 2'h0,
		hibr_cmd_write = 2'h1,
		hibr_cmd_read = 2'h2,
		hibr_cmd_stop = 2'h3
	} hibr_cmd_e;

endpackage : hibr_pkg

// ### hibr_if.sv
// carriers between the bridge modules: byte stream and register port
interface hibr_strm_if;
	logic valid;
	logic ready;
	logic [7:0] data;
	logic last;
	modport src (output valid, output data, output last, input ready);
	modport snk (input valid, input data, input last, output ready);
endinterface : hibr_strm_if

interface hibr_reg_if;
	logic wr_en;
	logic [15:0] wr_addr;
	logic [15:0] wr_data;
	logic [15:0] rd_addr;
	logic [15:0] rd_data;
	modport host (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport regs (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : hibr_reg_if

// ### hibr_buf.sv
// two-entry skid buffer on the in report byte path
module hibr_buf (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// streams
	hibr_strm_if.snk up,
	hibr_strm_if.src dn
);
	logic out_v_r;
	logic [8:0] out_d_r;
	logic skid_v_r;
	logic [8:0] skid_d_r;

	// ready is a flop, so a stall downstream never loses a byte
	assign up.ready = ~skid_v_r;
	assign dn.valid = out_v_r;
	assign dn.data = out_d_r[7:0];
	assign dn.last = out_d_r[8];

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			out_v_r <= 1'b0;
			out_d_r <= 9'h000;
			skid_v_r <= 1'b0;
			skid_d_r <= 9'h000;
		end else if (dn.ready || !out_v_r) begin
			if (skid_v_r) begin
				out_d_r <= skid_d_r;
				skid_v_r <= 1'b0;
			end else begin
				out_v_r <= up.valid;
				out_d_r <= {up.last, up.data};
			end
		end else if (up.valid && !skid_v_r) begin
			skid_v_r <= 1'b1;
			skid_d_r <= {up.last, up.data};
		end
	end

endmodule : hibr_buf

// ### hibr_regs.sv
// 16-bit register file reached through the feature reports
`include "hibr_defs.svh"
module hibr_regs (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// register port
	hibr_reg_if.regs rif,
	// pins and timing
	input wire logic [15:0] pin_level_i,
	output logic [15:0] scl_low_o,
	output logic [15:0] scl_high_o,
	output logic [15:0] pin_func_o,
	output logic [15:0] pin_dir_o,
	output logic [15:0] pin_drive_o,
	output logic [15:0] pin_hiz_o,
	output logic [15:0] pin_od_o,
	output logic [15:0] pin_pu_o,
	output logic [15:0] pin_pd_o,
	output logic [15:0] pin_irq_mask_o
);
	logic [15:0] regs_r [`HIBR_NREG];
	logic [15:0] drv_r;
	logic [3:0] widx;
	logic [3:0] ridx;

	function automatic logic [3:0] reg_idx(input logic [15:0] a);
		case (a)
			`HIBR_A_SCL_LO: reg_idx = `HIBR_I_SCL_LO;
			`HIBR_A_SCL_HI: reg_idx = `HIBR_I_SCL_HI;
			`HIBR_A_FUNC: reg_idx = `HIBR_I_FUNC;
			`HIBR_A_DIR: reg_idx = `HIBR_I_DIR;
			`HIBR_A_SET: reg_idx = `HIBR_I_SET;
			`HIBR_A_CLR: reg_idx = `HIBR_I_CLR;
			`HIBR_A_LEVEL: reg_idx = `HIBR_I_LEVEL;
			`HIBR_A_HIZ: reg_idx = `HIBR_I_HIZ;
			`HIBR_A_OD: reg_idx = `HIBR_I_OD;
			`HIBR_A_PU: reg_idx = `HIBR_I_PU;
			`HIBR_A_PD: reg_idx = `HIBR_I_PD;
			`HIBR_A_IRQM: reg_idx = `HIBR_I_IRQM;
			default: reg_idx = `HIBR_I_NONE;
		endcase
	endfunction : reg_idx

	assign widx = reg_idx(rif.wr_addr);
	assign ridx = reg_idx(rif.rd_addr);

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < `HIBR_NREG; i++) begin
				regs_r[i] <= `HIBR_REG_RST;
			end
		end else if (rif.wr_en && widx != `HIBR_I_NONE) begin
			regs_r[widx] <= rif.wr_data;
		end
	end

	// set and clear act on the drive latch; level writes it whole
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			drv_r <= `HIBR_REG_RST;
		end else if (rif.wr_en) begin
			case (widx)
				`HIBR_I_SET: drv_r <= drv_r | rif.wr_data;
				`HIBR_I_CLR: drv_r <= drv_r & ~rif.wr_data;
				`HIBR_I_LEVEL: drv_r <= rif.wr_data;
				default: drv_r <= drv_r;
			endcase
		end
	end

	// read mux; level reads the pins, unmapped reads zero
	always_comb begin
		if (ridx == `HIBR_I_NONE) begin
			rif.rd_data = `HIBR_REG_RST;
		end else if (ridx == `HIBR_I_LEVEL) begin
			rif.rd_data = pin_level_i;
		end else begin
			rif.rd_data = regs_r[ridx];
		end
	end

	assign scl_low_o = regs_r[`HIBR_I_SCL_LO];
	assign scl_high_o = regs_r[`HIBR_I_SCL_HI];
	assign pin_func_o = regs_r[`HIBR_I_FUNC];
	assign pin_dir_o = regs_r[`HIBR_I_DIR];
	assign pin_drive_o = drv_r;
	assign pin_hiz_o = regs_r[`HIBR_I_HIZ];
	assign pin_od_o = regs_r[`HIBR_I_OD];
	assign pin_pu_o = regs_r[`HIBR_I_PU];
	assign pin_pd_o = regs_r[`HIBR_I_PD];
	assign pin_irq_mask_o = regs_r[`HIBR_I_IRQM];

endmodule : hibr_regs

// ### hibr_top.sv
// hid report bridge: i2c command interpreter and feature register access
`include "hibr_defs.svh"
module hibr_top
	import hibr_pkg::*;
#(
	parameter int unsigned FREE_TO_CYC = `HIBR_FREE_TO_CYC,
	parameter int unsigned BYTE_TO_CYC = `HIBR_BYTE_TO_CYC
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// interrupt-out command bytes
	input wire logic out_valid_i,
	input wire logic [7:0] out_data_i,
	input wire logic out_last_i,
	output logic out_ready_o,
	// interrupt-in report bytes
	output logic in_valid_o,
	output logic [7:0] in_data_o,
	output logic in_last_o,
	input wire logic in_ready_i,
	// control feature report bytes
	input wire logic feat_valid_i,
	input wire logic [7:0] feat_data_i,
	input wire logic feat_last_i,
	output logic feat_rd_valid_o,
	output logic [7:0] feat_rd_data_o,
	// bus bit engine
	output logic eng_valid_o,
	output hibr_cmd_e eng_cmd_o,
	output logic [7:0] eng_wdata_o,
	output logic eng_ack_o,
	input wire logic eng_done_i,
	input wire logic eng_nak_i,
	input wire logic eng_arb_lost_i,
	input wire logic [7:0] eng_rdata_i,
	input wire logic bus_free_i,
	// timing and pins
	input wire logic [15:0] pin_level_i,
	output logic [15:0] scl_low_o,
	output logic [15:0] scl_high_o,
	output logic [15:0] pin_func_o,
	output logic [15:0] pin_dir_o,
	output logic [15:0] pin_drive_o,
	output logic [15:0] pin_hiz_o,
	output logic [15:0] pin_od_o,
	output logic [15:0] pin_pu_o,
	output logic [15:0] pin_pd_o,
	output logic [15:0] pin_irq_mask_o
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	hibr_strm_if rep_s ();
	hibr_strm_if in_s ();
	hibr_reg_if rif ();

	hibr_state_e state_r;
	logic out_rdy_r;
	logic [5:0] oidx_r;
	logic id_bad_r;
	logic [7:0] flags_r;
	logic [7:0] wcnt_q_r;
	logic [7:0] rcnt_q_r;
	logic [7:0] tgt_r;
	logic [7:0] wbuf_r [32];
	logic [7:0] rbuf_r [32];
	logic [5:0] wdone_r;
	logic [5:0] rdone_r;
	logic [5:0] ridx_r;
	logic [3:0] seq_r;
	logic [3:0] st_r;
	logic wait_r;
	logic eng_valid_r;
	hibr_cmd_e eng_cmd_r;
	logic [7:0] eng_wdata_r;
	logic eng_ack_r;
	logic [`HIBR_TMR_W-1:0] tmr_r;
	logic out_take;
	logic fmt_bad;
	logic to_free;
	logic to_byte;
	logic wlast;
	logic rlast;
	hibr_cmd_e cmd_c;
	logic [7:0] data_c;
	logic ack_c;
	logic [7:0] rep_byte;
	logic [2:0] fidx_r;
	logic [7:0] fbuf_r [5];
	logic fact_r;
	logic [2:0] flen_r;
	logic wr_en_r;
	logic [15:0] wr_addr_r;
	logic [15:0] wr_data_r;
	logic [15:0] rd_ptr_r;
	logic frd_v_r;
	logic [7:0] frd_d_r;
	logic [7:0] frd_hi_r;
	logic frd_ph_r;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// stop only when asked
	function automatic hibr_state_e fin_st(input logic [7:0] f);
		fin_st = f[`HIBR_CF_STOP] ? hibr_st_stop : hibr_st_reply;
	endfunction : fin_st

	// without a start the command continues an open transfer
	function automatic hibr_state_e data_st(input logic [7:0] w, input logic [7:0] r,
		input logic [7:0] f);
		if (w != 8'h00) begin
			data_st = hibr_st_wdata;
		end else if (r != 8'h00) begin
			data_st = hibr_st_rdata;
		end else begin
			data_st = fin_st(f);
		end
	endfunction : data_st

	function automatic logic is_last(input logic [5:0] done, input logic [7:0] req);
		is_last = ({2'h0, done} + 8'h01) == req;
	endfunction : is_last

	// ----------------------------------------
	// out command capture
	// ----------------------------------------
	assign out_take = out_valid_i && out_rdy_r;
	assign out_ready_o = out_rdy_r;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			oidx_r <= 6'h00;
			id_bad_r <= 1'b0;
			flags_r <= 8'h00;
			wcnt_q_r <= 8'h00;
			rcnt_q_r <= 8'h00;
			tgt_r <= 8'h00;
		end else if (out_take) begin
			oidx_r <= out_last_i ? 6'h00 : (oidx_r == 6'h3f ? oidx_r : oidx_r + 6'h01);
			case (oidx_r)
				6'h00: id_bad_r <= out_data_i != `HIBR_OUT_ID;
				`HIBR_OB_FLAGS: flags_r <= out_data_i;
				`HIBR_OB_WCNT: wcnt_q_r <= out_data_i;
				`HIBR_OB_RCNT: rcnt_q_r <= out_data_i;
				`HIBR_OB_ADDR: tgt_r <= out_data_i;
				default: tgt_r <= tgt_r;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (out_take && oidx_r >= `HIBR_OB_DATA && oidx_r <= `HIBR_OUT_LAST) begin
			wbuf_r[5'(oidx_r - `HIBR_OB_DATA)] <= out_data_i;
		end
	end

	// wrong id, length or size count
	assign fmt_bad = (oidx_r != `HIBR_OUT_LAST) || id_bad_r ||
		(wcnt_q_r > `HIBR_DATA_MAX) || (rcnt_q_r > `HIBR_DATA_MAX);

	// ----------------------------------------
	// timeouts
	// ----------------------------------------
	// one timer serves both limits; it runs only while something is awaited
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tmr_r <= '0;
		end else if (state_r == hibr_st_waitfree || wait_r) begin
			tmr_r <= tmr_r + `HIBR_TMR_W'(1);
		end else begin
			tmr_r <= '0;
		end
	end

	assign to_free = (state_r == hibr_st_waitfree) && !bus_free_i &&
		(tmr_r == `HIBR_TMR_W'(FREE_TO_CYC - 1));
	assign to_byte = wait_r && !eng_done_i && (tmr_r == `HIBR_TMR_W'(BYTE_TO_CYC - 1));

	// ----------------------------------------
	// engine command selection
	// ----------------------------------------
	assign wlast = is_last(wdone_r, wcnt_q_r);
	assign rlast = is_last(rdone_r, rcnt_q_r);

	always_comb begin
		cmd_c = hibr_cmd_write;
		data_c = 8'h00;
		ack_c = 1'b1;
		case (state_r)
			hibr_st_start, hibr_st_restart: cmd_c = hibr_cmd_start;
			hibr_st_addr: data_c = {tgt_r[7:1], 1'b0};
			hibr_st_raddr: data_c = {tgt_r[7:1], 1'b1};
			hibr_st_wdata: data_c = wbuf_r[wdone_r[4:0]];
			hibr_st_rdata: begin
				cmd_c = hibr_cmd_read;
				ack_c = rlast ? flags_r[`HIBR_CF_ACKL] : 1'b1;
			end
			hibr_st_stop: cmd_c = hibr_cmd_stop;
			default: cmd_c = hibr_cmd_write;
		endcase
	end

	// ----------------------------------------
	// transfer sequencer
	// ----------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_r <= hibr_st_rx;
			out_rdy_r <= 1'b1;
			wait_r <= 1'b0;
			eng_valid_r <= 1'b0;
			eng_cmd_r <= hibr_cmd_start;
			eng_wdata_r <= 8'h00;
			eng_ack_r <= 1'b0;
			wdone_r <= 6'h00;
			rdone_r <= 6'h00;
			ridx_r <= 6'h00;
			seq_r <= 4'h0;
			st_r <= 4'h0;
		end else begin
			eng_valid_r <= 1'b0;
			case (state_r)
				hibr_st_rx: begin
					if (out_take && out_last_i) begin
						out_rdy_r <= 1'b0;
						seq_r <= flags_r[7:4];
						wdone_r <= 6'h00;
						rdone_r <= 6'h00;
						ridx_r <= 6'h00;
						st_r <= 4'h0;
						if (fmt_bad) begin
							st_r[`HIBR_SF_ERR] <= 1'b1;
							state_r <= hibr_st_reply;
						end else if (flags_r[`HIBR_CF_START]) begin
							state_r <= hibr_st_waitfree;
						end else begin
							state_r <= data_st(wcnt_q_r, rcnt_q_r, flags_r);
						end
					end
				end
				hibr_st_waitfree: begin
					if (bus_free_i) begin
						state_r <= hibr_st_start;
					end else if (to_free) begin
						st_r[`HIBR_SF_TO] <= 1'b1;
						state_r <= hibr_st_reply;
					end
				end
				hibr_st_reply: begin
					if (rep_s.ready) begin
						ridx_r <= ridx_r + 6'h01;
						if (ridx_r == `HIBR_IN_LAST) begin
							state_r <= hibr_st_rx;
							out_rdy_r <= 1'b1;
						end
					end
				end
				default: begin
					if (!wait_r) begin
						eng_valid_r <= 1'b1;
						eng_cmd_r <= cmd_c;
						eng_wdata_r <= data_c;
						eng_ack_r <= ack_c;
						wait_r <= 1'b1;
					end else if (eng_done_i) begin
						wait_r <= 1'b0;
						if (eng_arb_lost_i) begin
							st_r[`HIBR_SF_ARB] <= 1'b1;
							state_r <= hibr_st_reply;
						end else if (eng_nak_i && cmd_c == hibr_cmd_write) begin
							st_r[`HIBR_SF_NAK] <= 1'b1;
							state_r <= hibr_st_stop;
						end else begin
							case (state_r)
								hibr_st_start: begin
									if (wcnt_q_r != 8'h00 || rcnt_q_r == 8'h00) begin
										state_r <= hibr_st_addr;
									end else begin
										state_r <= hibr_st_raddr;
									end
								end
								hibr_st_restart: state_r <= hibr_st_raddr;
								hibr_st_addr: begin
									state_r <= (wcnt_q_r != 8'h00) ? hibr_st_wdata : fin_st(flags_r);
								end
								hibr_st_wdata: begin
									wdone_r <= wdone_r + 6'h01;
									if (wlast) begin
										if (rcnt_q_r != 8'h00) begin
											state_r <= hibr_st_restart;
										end else begin
											state_r <= fin_st(flags_r);
										end
									end
								end
								hibr_st_raddr: state_r <= hibr_st_rdata;
								hibr_st_rdata: begin
									rdone_r <= rdone_r + 6'h01;
									if (rlast) begin
										state_r <= fin_st(flags_r);
									end
								end
								default: state_r <= hibr_st_reply;
							endcase
						end
					end else if (to_byte) begin
						wait_r <= 1'b0;
						st_r[`HIBR_SF_TO] <= 1'b1;
						state_r <= hibr_st_reply;
					end
				end
			endcase
		end
	end

	assign eng_valid_o = eng_valid_r;
	assign eng_cmd_o = eng_cmd_r;
	assign eng_wdata_o = eng_wdata_r;
	assign eng_ack_o = eng_ack_r;

	// ----------------------------------------
	// read data store
	// ----------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 32; i++) begin
				rbuf_r[i] <= 8'h00;
			end
		end else if (state_r == hibr_st_rdata && wait_r && eng_done_i && !eng_arb_lost_i) begin
			rbuf_r[rdone_r[4:0]] <= eng_rdata_i;
		end
	end

	// ----------------------------------------
	// in report assembly
	// ----------------------------------------
	// report built only in the reply state, after the transfer ended
	always_comb begin
		case (ridx_r)
			`HIBR_IB_STAT: rep_byte = {seq_r, st_r};
			`HIBR_IB_WCNT: rep_byte = {2'h0, wdone_r};
			`HIBR_IB_RCNT: rep_byte = {2'h0, rdone_r};
			`HIBR_IB_RSVD: rep_byte = 8'h00;
			default: rep_byte = rbuf_r[5'(ridx_r - `HIBR_IB_DATA)];
		endcase
	end

	assign rep_s.valid = state_r == hibr_st_reply;
	assign rep_s.data = rep_byte;
	assign rep_s.last = ridx_r == `HIBR_IN_LAST;

	hibr_buf u_buf (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.up(rep_s),
		.dn(in_s)
	);

	assign in_valid_o = in_s.valid;
	assign in_data_o = in_s.data;
	assign in_last_o = in_s.last;
	assign in_s.ready = in_ready_i;

	// ----------------------------------------
	// feature report capture
	// ----------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			fidx_r <= 3'h0;
			fact_r <= 1'b0;
			flen_r <= 3'h0;
			for (int i = 0; i < 5; i++) begin
				fbuf_r[i] <= 8'h00;
			end
		end else begin
			fact_r <= feat_valid_i && feat_last_i;
			if (feat_valid_i) begin
				if (fidx_r != `HIBR_FIDX_MAX) begin
					fbuf_r[fidx_r] <= feat_data_i;
				end
				// too long a report decodes to a length no report has
				flen_r <= fidx_r + 3'h1;
				fidx_r <= feat_last_i ? 3'h0 :
					(fidx_r == `HIBR_FIDX_MAX ? fidx_r : fidx_r + 3'h1);
			end
		end
	end

	// ----------------------------------------
	// feature report decode
	// ----------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wr_en_r <= 1'b0;
			wr_addr_r <= 16'h0000;
			wr_data_r <= 16'h0000;
		end else begin
			wr_en_r <= fact_r && fbuf_r[0] == `HIBR_FID_WR && flen_r == `HIBR_FLEN_WR;
			wr_addr_r <= {fbuf_r[2], fbuf_r[1]};
			wr_data_r <= {fbuf_r[4], fbuf_r[3]};
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rd_ptr_r <= 16'h0000;
		end else if (fact_r && fbuf_r[0] == `HIBR_FID_PTR && flen_r == `HIBR_FLEN_PTR) begin
			rd_ptr_r <= {fbuf_r[2], fbuf_r[1]};
		end
	end

	// two data bytes, low then high
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			frd_v_r <= 1'b0;
			frd_d_r <= 8'h00;
			frd_hi_r <= 8'h00;
			frd_ph_r <= 1'b0;
		end else if (frd_ph_r) begin
			frd_v_r <= 1'b1;
			frd_d_r <= frd_hi_r;
			frd_ph_r <= 1'b0;
		end else if (fact_r && fbuf_r[0] == `HIBR_FID_RD && flen_r == `HIBR_FLEN_RD) begin
			frd_v_r <= 1'b1;
			frd_d_r <= rif.rd_data[7:0];
			frd_hi_r <= rif.rd_data[15:8];
			frd_ph_r <= 1'b1;
		end else begin
			frd_v_r <= 1'b0;
		end
	end

	assign feat_rd_valid_o = frd_v_r;
	assign feat_rd_data_o = frd_d_r;

	// ----------------------------------------
	// register file
	// ----------------------------------------
	assign rif.wr_en = wr_en_r;
	assign rif.wr_addr = wr_addr_r;
	assign rif.wr_data = wr_data_r;
	assign rif.rd_addr = rd_ptr_r;

	hibr_regs u_regs (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.rif(rif),
		.pin_level_i(pin_level_i),
		.scl_low_o(scl_low_o),
		.scl_high_o(scl_high_o),
		.pin_func_o(pin_func_o),
		.pin_dir_o(pin_dir_o),
		.pin_drive_o(pin_drive_o),
		.pin_hiz_o(pin_hiz_o),
		.pin_od_o(pin_od_o),
		.pin_pu_o(pin_pu_o),
		.pin_pd_o(pin_pd_o),
		.pin_irq_mask_o(pin_irq_mask_o)
	);

endmodule : hibr_top

// ### hibr_top_asserts.sv
// port checker of the bridge top
module hibr_top_asserts (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// report streams
	input wire logic out_valid_i,
	input wire logic out_last_i,
	input wire logic out_ready_o,
	input wire logic in_valid_o,
	input wire logic in_ready_i,
	input wire logic in_last_o,
	input wire logic [7:0] in_data_o,
	// engine and feature
	input wire logic eng_valid_o,
	input wire logic feat_valid_i,
	input wire logic feat_last_i,
	input wire logic [7:0] feat_data_i,
	input wire logic feat_rd_valid_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	property p_drop; out_valid_i && out_ready_o && out_last_i |=> !out_ready_o; endproperty
	a_drop: assert property (p_drop) else $error("ready kept");
	property p_hold; in_valid_o && !in_ready_i |=> in_valid_o && $stable(in_data_o); endproperty
	a_hold: assert property (p_hold) else $error("byte lost");
	property p_late; $rose(in_valid_o) |-> !out_ready_o; endproperty
	a_late: assert property (p_late) else $error("early report");
	property p_eng; eng_valid_o |-> !out_ready_o ##1 !eng_valid_o; endproperty
	a_eng: assert property (p_eng) else $error("stray command");
	// a lone id byte is a read request; pulses land two cycles later
	property p_rd; feat_valid_i && feat_last_i && feat_data_i == 8'h5a && !$past(feat_valid_i)
		|-> ##2 feat_rd_valid_o ##1 feat_rd_valid_o ##1 !feat_rd_valid_o; endproperty
	a_rd: assert property (p_rd) else $error("read timing");
	property p_ans; $fell(out_ready_o) |-> ##[1:1000] in_valid_o; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_back; in_valid_o && in_ready_i && in_last_o |=> out_ready_o; endproperty
	a_back: assert property (p_back) else $error("ready not back");
	property p_last; in_last_o |-> in_valid_o; endproperty
	a_last: assert property (p_last) else $error("stray last");
endmodule : hibr_top_asserts

bind hibr_top hibr_top_asserts hibr_top_asserts_i (.*);

// ### hibr_eng_model.sv
// bit engine model facing the bridge
module hibr_eng_model
	import hibr_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// commands; mode 1 nak, 2 lost arbitration, 3 silent
	input wire logic eng_valid_i,
	input wire hibr_cmd_e eng_cmd_i,
	input wire logic [1:0] mode_i,
	input wire logic slow_i,
	// answers
	output logic eng_done_o,
	output logic eng_nak_o,
	output logic eng_arb_o,
	output logic [7:0] eng_rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_r;
	logic [7:0] rd_r;
	hibr_cmd_e cmd_r;
	assign eng_nak_o = eng_done_o && mode_i == 2'h1 && cmd_r == hibr_cmd_write;
	assign eng_arb_o = eng_done_o && mode_i == 2'h2;
	// garbage unless done
	assign eng_rdata_o = eng_done_o ? rd_r : ~rd_r;
	always_ff @(posedge sys_clk_i) begin
		eng_done_o <= !rst_i && cnt_r == 4'h1;
		if (rst_i)
			cnt_r <= 4'h0;
		else if (eng_valid_i)
			cnt_r <= mode_i == 2'h3 ? 4'h0 : slow_i ? 4'h9 : 4'h2;
		else if (cnt_r != 4'h0)
			cnt_r <= cnt_r - 4'h1;
		if (eng_valid_i)
			cmd_r <= eng_cmd_i;
		if (rst_i || eng_valid_i && eng_cmd_i == hibr_cmd_start)
			rd_r <= 8'hc0;
		else if (eng_done_o && cmd_r == hibr_cmd_read)
			rd_r <= rd_r + 8'h01;
	end
endmodule : hibr_eng_model

// ### tb_top.sv
// self-checking bench of the bridge top
module tb_top
	import hibr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic out_valid_i = 1'b0;
	logic [7:0] out_data_i = 8'h00;
	logic out_last_i = 1'b0;
	logic in_ready_i = 1'b1;
	logic feat_valid_i = 1'b0;
	logic [7:0] feat_data_i = 8'h00;
	logic feat_last_i = 1'b0;
	logic bus_free_i = 1'b1;
	logic [15:0] pin_level_i = 16'h0000;
	logic out_ready_o, in_valid_o, in_last_o, eng_valid_o, feat_rd_valid_o, seen, ak, eng_ack_o;
	logic [7:0] in_data_o, feat_rd_data_o, eng_wdata_o, eng_rdata_i, aw;
	logic [15:0] scl_low_o, rd_q;
	hibr_cmd_e eng_cmd_o;
	logic eng_done_i, eng_nak_i, eng_arb_lost_i;
	logic eng_slow = 1'b0;
	logic [1:0] eng_mode = 2'h0;
	int fails = 0;
	int tests_run = 0;
	always #5 sys_clk_i = ~sys_clk_i;
	hibr_top #(.FREE_TO_CYC(200), .BYTE_TO_CYC(50)) hibr_top_i (.*,
		.scl_high_o(), .pin_func_o(), .pin_dir_o(), .pin_drive_o(), .pin_hiz_o(),
		.pin_od_o(), .pin_pu_o(), .pin_pd_o(), .pin_irq_mask_o());
	hibr_eng_model hibr_eng_model_i (.sys_clk_i, .rst_i, .eng_valid_i(eng_valid_o),
		.eng_cmd_i(eng_cmd_o), .mode_i(eng_mode), .slow_i(eng_slow), .eng_done_o(eng_done_i),
		.eng_nak_o(eng_nak_i), .eng_arb_o(eng_arb_lost_i), .eng_rdata_o(eng_rdata_i));
	// read pulses shift in, low byte first
	always @(posedge sys_clk_i) if (feat_rd_valid_o) rd_q = {feat_rd_data_o, rd_q[15:8]};
	always @(posedge sys_clk_i) if (eng_valid_o && eng_cmd_o == hibr_cmd_read) ak = eng_ack_o;
	always @(posedge sys_clk_i) if (eng_valid_o && eng_cmd_o == hibr_cmd_write && !seen) begin
		aw = eng_wdata_o;
		seen = 1'b1;
	end
	task chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task fsend(input logic [39:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			feat_valid_i <= 1'b1;
			feat_data_i <= v[8*i +: 8];
			feat_last_i <= i == n - 1;
			@(posedge sys_clk_i);
		end
		feat_valid_i <= 1'b0;
		feat_last_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
	endtask : fsend
	task rdreg(input logic [15:0] a);
		fsend({16'h0, a, 8'h4b}, 3);
		rd_q = 'x;
		fsend(40'h5a, 1);
	endtask : rdreg
	task xfer(input logic [7:0] fl, wc, rc, id, input logic [1:0] md,
		input logic [15:0] st, nw, nr);
		logic [15:0] rep [36];
		int n;
		eng_mode <= md;
		seen = 1'b0;
		for (int k = 0; k < 37; k++) begin
			out_valid_i <= 1'b1;
			out_data_i <= k == 0 ? id : k == 1 ? fl : k == 2 ? wc : k == 3 ? rc : 8'(k + 76);
			out_last_i <= k == 36;
			@(posedge sys_clk_i);
			while (!out_ready_o) @(posedge sys_clk_i);
		end
		out_valid_i <= 1'b0;
		out_last_i <= 1'b0;
		n = 0;
		// stalls fill the buffer
		for (int c = 0; c < 3000 && n < 36; c++) begin
			in_ready_i <= c[2];
			@(posedge sys_clk_i);
			if (in_valid_o && in_ready_i) begin
				chk(16'(in_last_o), 16'(n == 35));
				rep[n] = 16'(in_data_o);
				n++;
			end
		end
		chk(16'(n), 16'd36);
		chk(rep[0], st);
		chk(rep[1], nw);
		chk(rep[2], nr);
		for (int i = 0; i < nr; i++) chk(rep[4 + i], 16'hc0 + 16'(i));
	endtask : xfer
	task t_regs;
		rdreg(16'h03c9);
		chk(rd_q, 16'h0000);
		fsend({16'h1234, 16'h0341, 8'h3c}, 5);
		chk(scl_low_o, 16'h1234);
		rdreg(16'h0341);
		chk(rd_q, 16'h1234);
		rdreg(16'h0342);
		chk(rd_q, 16'h0000);
	endtask : t_regs
	task t_err;
		xfer(8'h31, 8'h21, 8'h00, 8'h00, 2'h0, 16'h0031, 16'h0000, 16'h0000);
		xfer(8'h91, 8'h01, 8'h00, 8'h01, 2'h0, 16'h0091, 16'h0000, 16'h0000);
	endtask : t_err
	task t_good;
		xfer(8'h53, 8'h02, 8'h03, 8'h00, 2'h0, 16'h0050, 16'h0002, 16'h0003);
		chk(16'(aw), 16'h0050);
		chk(16'(ak), 16'h0000);
		eng_slow <= 1'b1;
		xfer(8'h67, 8'h00, 8'h20, 8'h00, 2'h0, 16'h0060, 16'h0000, 16'h0020);
		chk(16'(aw), 16'h0051);
		eng_slow <= 1'b0;
	endtask : t_good
	task t_fault;
		xfer(8'h73, 8'h02, 8'h00, 8'h00, 2'h1, 16'h0072, 16'h0000, 16'h0000);
		xfer(8'h83, 8'h02, 8'h00, 8'h00, 2'h2, 16'h0084, 16'h0000, 16'h0000);
		xfer(8'h93, 8'h02, 8'h00, 8'h00, 2'h3, 16'h0098, 16'h0000, 16'h0000);
		bus_free_i <= 1'b0;
		xfer(8'ha3, 8'h02, 8'h00, 8'h00, 2'h0, 16'h00a8, 16'h0000, 16'h0000);
		bus_free_i <= 1'b1;
	endtask : t_fault
	task tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (3) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		t_regs;
		t_err;
		t_good;
		t_fault;
		tally_and_finish;
	end
	initial begin
		#500000;
		fails++;
		tally_and_finish;
	end
endmodule : tb_top
